// File: src/pmv_pkg.sv
// package: constants and types for program memory vectoring and table lookup
package pmv_pkg;
  localparam int PC_W = 10;
  localparam logic [PC_W-1:0] RESET_VECTOR = 10'h000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 10'h008;
  localparam logic [PC_W-1:0] PC_ONE = 10'h001;
  localparam logic [PC_W-1:0] USER_TOP = 10'h3fb;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] FLAG_POWER = 8'h80;
  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam logic [7:0] IMM_BAD_A = 8'he6;
  localparam logic [7:0] IMM_BAD_B = 8'he7;
  localparam int TO_BIT = 7;
  localparam int PD_BIT = 6;
  localparam logic [7:0] CAUSE_MASK = 8'hc0;
  // apb register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PC = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_FLAG = 8'h0c;
  localparam logic [7:0] ADDR_IDXH = 8'h10;
  localparam logic [7:0] ADDR_IDXL = 8'h14;
  localparam logic [7:0] ADDR_HIGH = 8'h18;
  localparam logic [7:0] ADDR_SAVE = 8'h1c;
  // control register command bits (write one to act)
  localparam int CMD_TREAD = 0;
  localparam int CMD_PUSH = 1;
  localparam int CMD_POP = 2;
  localparam int CMD_IRQ = 3;
  localparam int CMD_STEP = 4;
  typedef enum logic [1:0] {
    PMV_RST_POWER,
    PMV_RST_WDT,
    PMV_RST_PIN
  } pmv_cause_t;
  typedef enum logic [1:0] {
    PMV_IDLE,
    PMV_FETCH,
    PMV_DONE
  } pmv_state_t;
endpackage : pmv_pkg

// File: src/pmv_rom_if.sv
// interface: table read request between engine and top
`timescale 1ns/100ps
`default_nettype none
interface pmv_rom_if;
  import pmv_pkg::*;
  logic start;
  logic [15:0] addr;
  logic busy;
  logic done;
  logic [15:0] word;
  modport eng (input start, input addr, output busy, output done, output word);
  modport top (output start, output addr, input busy, input done, input word);
endinterface : pmv_rom_if
`default_nettype wire

// File: src/pmv_table_read.sv
// table read engine: issues a program memory read and captures the word
`timescale 1ns/100ps
`default_nettype none
module pmv_table_read
  import pmv_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  pmv_rom_if.eng req,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [15:0] mem_data
);
  pmv_state_t state_q;
  logic [15:0] word_q;
  // one cycle address, one cycle data; memory read is combinational, data taken in the mem_rd cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PMV_IDLE;
    end else if (clk_en) begin
      case (state_q)
        PMV_IDLE: if (req.start) state_q <= PMV_FETCH;
        PMV_FETCH: state_q <= PMV_DONE;
        default: state_q <= PMV_IDLE;
      endcase
    end
  end
  // address latched from the index registers at start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr <= 16'h0000;
    end else if (clk_en && state_q == PMV_IDLE && req.start) begin
      mem_addr <= req.addr;
    end
  end
  // data captured at the end of the read cycle, while mem_rd is high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_q <= 16'h0000;
    end else if (clk_en && state_q == PMV_FETCH) begin
      word_q <= mem_data;
    end
  end
  assign mem_rd = (state_q == PMV_FETCH);
  assign req.busy = (state_q != PMV_IDLE);
  assign req.done = clk_en && (state_q == PMV_DONE);
  assign req.word = word_q;
endmodule : pmv_table_read
`default_nettype wire

// File: src/pmv_ctx_save.sv
// one level context save buffer for accumulator and flags
`timescale 1ns/100ps
`default_nettype none
module pmv_ctx_save
  import pmv_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic push,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] flag_in,
  output logic [7:0] acc_saved,
  output logic [7:0] flag_saved
);
  // single slot: a second push overwrites the first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_saved <= ACC_RESET;
      flag_saved <= FLAG_RESET;
    end else if (clk_en && push) begin
      acc_saved <= acc_in;
      flag_saved <= flag_in & ~CAUSE_MASK;
    end
  end
endmodule : pmv_ctx_save
`default_nettype wire

// File: src/pmv_top.sv
// program counter vectoring, table lookup and context save with apb access
// Summary of operation
// - any reset starts fetch at reset vector word zero
// - power, pin or watchdog reset clear pc and system registers
// - reset cause kept in timeout and power down flags
// - interrupt pushes pc to stack, then pc becomes word eight
// - push/pop copy accumulator and flags, reset-cause flags untouched
// - table address: upper index bits 15..8, lower index bits 7..0
// - table read: low byte to accumulator, high byte to high register
// - immediates e6/e7 unusable for indices; tables avoid them
// - upper index never carries when lower index wraps
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pmv_top
  import pmv_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic wdt_reset,
  input wire logic pin_reset,
  input wire logic irq_take,
  output logic stack_push,
  output logic [pmv_pkg::PC_W-1:0] stack_data,
  output logic [pmv_pkg::PC_W-1:0] pc,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [15:0] mem_data,
  output logic timeout_flag,
  output logic power_down_flag,
  output logic imm_reject,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [PC_W-1:0] pc_q;
  logic [7:0] acc_q;
  logic [7:0] flag_q;
  logic [7:0] idx_hi_q;
  logic [7:0] idx_lo_q;
  logic [7:0] high_q;
  logic [7:0] acc_saved;
  logic [7:0] flag_saved;
  logic stack_push_q;
  logic [PC_W-1:0] stack_data_q;
  logic soft_rst;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic cmd_tread;
  logic cmd_push;
  logic cmd_pop;
  logic irq_go;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  pmv_rom_if rom ();

  // apb access phase: zero wait states while clk_en is high; pready follows clk_en
  assign wr_en = psel && penable && pwrite && clk_en;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_PC) || (paddr == ADDR_ACC) ||
                   (paddr == ADDR_FLAG) || (paddr == ADDR_IDXH) || (paddr == ADDR_IDXL) ||
                   (paddr == ADDR_HIGH) || (paddr == ADDR_SAVE);
  assign pready = clk_en;
  assign pslverr = psel && penable && !addr_ok;
  assign cmd_tread = wr_en && paddr == ADDR_CTRL && pwdata[CMD_TREAD] && !rom.busy;
  assign cmd_push = wr_en && paddr == ADDR_CTRL && pwdata[CMD_PUSH];
  assign cmd_pop = wr_en && paddr == ADDR_CTRL && pwdata[CMD_POP];
  assign irq_go = clk_en && (irq_take || (wr_en && paddr == ADDR_CTRL && pwdata[CMD_IRQ]));
  // watchdog and pin resets clear pc, accumulator, high and index registers as power-on reset does; cause flags differ
  assign soft_rst = wdt_reset || pin_reset;

  // table read address formed straight from the two index registers
  assign rom.start = cmd_tread;
  assign rom.addr = {idx_hi_q, idx_lo_q};

  pmv_table_read u_tread (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .req(rom),
    .mem_addr(mem_addr),
    .mem_rd(mem_rd),
    .mem_data(mem_data)
  );

  pmv_ctx_save u_ctx (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .push(cmd_push),
    .acc_in(acc_q),
    .flag_in(flag_q),
    .acc_saved(acc_saved),
    .flag_saved(flag_saved)
  );

  // program counter: reset vector, interrupt vector, direct write, or single step
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= RESET_VECTOR;
    end else if (clk_en) begin
      if (soft_rst) begin
        pc_q <= RESET_VECTOR;
      end else if (irq_go) begin
        pc_q <= IRQ_VECTOR;
      end else if (wr_en && paddr == ADDR_PC) begin
        pc_q <= pwdata[PC_W-1:0];
      end else if (wr_en && paddr == ADDR_CTRL && pwdata[CMD_STEP]) begin
        pc_q <= pc_q + PC_ONE;
      end
    end
  end

  // stack push carries the pc held before the vector load
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_push_q <= 1'b0;
      stack_data_q <= RESET_VECTOR;
    end else if (clk_en) begin
      stack_push_q <= irq_go && !soft_rst;
      if (irq_go && !soft_rst) begin
        stack_data_q <= pc_q;
      end
    end
  end

  // reset cause: power gives 1/0, watchdog 0/0, pin 1/1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= FLAG_POWER; // power-on: timeout set, power down clear
    end else if (clk_en) begin
      if (wdt_reset) begin
        flag_q <= FLAG_RESET;
      end else if (pin_reset) begin
        flag_q <= CAUSE_MASK;
      end else if (cmd_pop) begin
        flag_q <= (flag_saved & ~CAUSE_MASK) | (flag_q & CAUSE_MASK);
      end else if (wr_en && paddr == ADDR_FLAG) begin
        flag_q <= (pwdata[7:0] & ~CAUSE_MASK) | (flag_q & CAUSE_MASK);
      end
    end
  end

  // accumulator: table read low byte, pop, or direct write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= ACC_RESET;
    end else if (clk_en) begin
      if (soft_rst) begin
        acc_q <= ACC_RESET;
      end else if (rom.done) begin
        acc_q <= rom.word[7:0];
      end else if (cmd_pop) begin
        acc_q <= acc_saved;
      end else if (wr_en && paddr == ADDR_ACC) begin
        acc_q <= pwdata[7:0];
      end
    end
  end

  // high byte register takes the upper half of the table word
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      high_q <= IDX_RESET;
    end else if (clk_en) begin
      if (soft_rst) begin
        high_q <= IDX_RESET;
      end else if (rom.done) begin
        high_q <= rom.word[15:8];
      end else if (wr_en && paddr == ADDR_HIGH) begin
        high_q <= pwdata[7:0];
      end
    end
  end

  // index registers: independent bytes, no carry from low to high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_hi_q <= IDX_RESET;
      idx_lo_q <= IDX_RESET;
    end else if (clk_en) begin
      if (soft_rst) begin
        idx_hi_q <= IDX_RESET;
        idx_lo_q <= IDX_RESET;
      end else begin
        if (wr_en && paddr == ADDR_IDXH && !imm_reject) begin
          idx_hi_q <= pwdata[7:0];
        end
        if (wr_en && paddr == ADDR_IDXL && !imm_reject) begin
          idx_lo_q <= pwdata[7:0]; // wrap leaves upper index alone
        end
      end
    end
  end

  // immediate load of e6/e7 is not supported; written value is dropped
  assign imm_reject = wr_en && (paddr == ADDR_IDXH || paddr == ADDR_IDXL) &&
                      (pwdata[7:0] == IMM_BAD_A || pwdata[7:0] == IMM_BAD_B);

  // read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (paddr == ADDR_CTRL) begin
      rdata_d = {31'h0000_0000, rom.busy};
    end else if (paddr == ADDR_PC) begin
      rdata_d = {22'h00_0000, pc_q};
    end else if (paddr == ADDR_ACC) begin
      rdata_d = {24'h00_0000, acc_q};
    end else if (paddr == ADDR_FLAG) begin
      rdata_d = {24'h00_0000, flag_q};
    end else if (paddr == ADDR_IDXH) begin
      rdata_d = {24'h00_0000, idx_hi_q};
    end else if (paddr == ADDR_IDXL) begin
      rdata_d = {24'h00_0000, idx_lo_q};
    end else if (paddr == ADDR_HIGH) begin
      rdata_d = {24'h00_0000, high_q};
    end else if (paddr == ADDR_SAVE) begin
      rdata_d = {16'h0000, flag_saved, acc_saved};
    end
  end

  // read data registered in setup so it is stable in the access phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata_q <= rdata_d;
    end
  end

  assign prdata = rd_en ? prdata_q : 32'h0000_0000;
  assign pc = pc_q;
  assign stack_push = stack_push_q;
  assign stack_data = stack_data_q;
  assign timeout_flag = flag_q[TO_BIT];
  assign power_down_flag = flag_q[PD_BIT];

  // checks
  sequence s_irq_vec;
    pc_q == IRQ_VECTOR;
  endsequence
  property p_irq_vector;
    @(posedge clk) disable iff (!reset_n) irq_go && !soft_rst |=> s_irq_vec ##0 stack_push_q;
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("pc not at interrupt vector");
  property p_stack_data;
    @(posedge clk) disable iff (!reset_n) irq_go && !soft_rst |=> stack_data_q == $past(pc_q);
  endproperty
  a_stack_data: assert property (p_stack_data) else $error("stacked pc wrong");
  property p_soft_reset_pc;
    @(posedge clk) disable iff (!reset_n) clk_en && soft_rst |=> pc_q == RESET_VECTOR && acc_q == ACC_RESET;
  endproperty
  a_soft_reset_pc: assert property (p_soft_reset_pc) else $error("reset did not vector");
  property p_wdt_flags;
    @(posedge clk) disable iff (!reset_n) clk_en && wdt_reset |=> !timeout_flag && !power_down_flag;
  endproperty
  a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog cause wrong");
  property p_pin_flags;
    @(posedge clk) disable iff (!reset_n) clk_en && pin_reset && !wdt_reset |=> timeout_flag && power_down_flag;
  endproperty
  a_pin_flags: assert property (p_pin_flags) else $error("pin cause wrong");
  property p_pop_keeps_cause;
    @(posedge clk) disable iff (!reset_n) cmd_pop && !soft_rst |=> $stable(flag_q[7:6]);
  endproperty
  a_pop_keeps_cause: assert property (p_pop_keeps_cause) else $error("pop changed cause");
  property p_tread_addr;
    @(posedge clk) disable iff (!reset_n) cmd_tread |=> mem_addr == $past(rom.addr);
  endproperty
  a_tread_addr: assert property (p_tread_addr) else $error("table address wrong");
  property p_tread_result;
    @(posedge clk) disable iff (!reset_n) rom.done && !soft_rst |=>
      acc_q == $past(rom.word[7:0]) && high_q == $past(rom.word[15:8]);
  endproperty
  a_tread_result: assert property (p_tread_result) else $error("table bytes wrong");
  property p_no_carry;
    @(posedge clk) disable iff (!reset_n) clk_en && !soft_rst && !(wr_en && paddr == ADDR_IDXH) |=> $stable(idx_hi_q);
  endproperty
  a_no_carry: assert property (p_no_carry) else $error("upper index moved");
  // power-on release: cause flags show the power-on code at the first edge
  property p_power_flags;
    @(posedge clk) $rose(reset_n) |-> timeout_flag && !power_down_flag && pc_q == RESET_VECTOR;
  endproperty
  a_power_flags: assert property (p_power_flags) else $error("power-on cause wrong");
  // clock enable low freezes program counter, flags and accumulator
  property p_freeze;
    @(posedge clk) disable iff (!reset_n) !clk_en |=> $stable(pc_q) && $stable(flag_q) && $stable(acc_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  // push stores accumulator and flags with the cause bits dropped
  property p_push_save;
    @(posedge clk) disable iff (!reset_n) cmd_push |=>
      acc_saved == $past(acc_q) && flag_saved == ($past(flag_q) & ~CAUSE_MASK);
  endproperty
  a_push_save: assert property (p_push_save) else $error("push saved wrong");
  // a taken table read is in its fetch cycle one edge later
  sequence s_fetch;
    mem_rd && rom.busy;
  endsequence
  property p_tread_fetch;
    @(posedge clk) disable iff (!reset_n) cmd_tread |=> s_fetch;
  endproperty
  a_tread_fetch: assert property (p_tread_fetch) else $error("table fetch missing");
endmodule : pmv_top
`default_nettype wire

// File: sim/pmv_rom_model.sv
// program memory model answering table reads from the block
`timescale 1ns/100ps
`default_nettype none
module pmv_rom_model
  import pmv_pkg::*;
#(
  parameter logic [15:0] NOP_WORD = 16'h0000
)
(
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [15:0] mem_data
);
  logic [15:0] last_q;
  logic [15:0] word;
  // table contents: a no-op at the interrupt vector, filler in the reserved top words
  always_comb begin
    if (mem_addr == {6'h00, IRQ_VECTOR}) begin
      word = NOP_WORD;
    end else if (mem_addr[9:0] > USER_TOP) begin
      word = 16'hffff;
    end else begin
      word = {mem_addr[7:0] ^ 8'ha5, mem_addr[15:8] ^ 8'h3c};
    end
  end
  // bus released outside a fetch: show the inverse so stale data never looks valid
  always_ff @(posedge clk) begin
    if (mem_rd) begin
      last_q <= word;
    end
  end
  assign mem_data = mem_rd ? word : ~last_q;
endmodule : pmv_rom_model
`default_nettype wire

// File: sim/pmv_top_bench.sv
// self-checking bench for vectoring, table lookup and context save
`timescale 1ns/100ps
`default_nettype none
module pmv_top_bench;
  import pmv_pkg::*;
  logic clk = 0, reset_n = 0, clk_en = 1, wdt_reset = 0, pin_reset = 0, irq_take = 0;
  logic psel = 0, penable = 0, pwrite = 0, err, rej;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic stack_push, mem_rd, timeout_flag, power_down_flag, imm_reject, pready, pslverr;
  logic [PC_W-1:0] stack_data, pc;
  logic [15:0] mem_addr, mem_data, seen_addr, w;
  logic [15:0] taddr [4] = '{16'h0102, 16'h03ff, 16'h0008, 16'h3f00};
  int num_errors = 0, cmp_count = 0;
  // clock generation
  always #50 clk = ~clk;
  pmv_top u_dut(.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .wdt_reset(wdt_reset), .pin_reset(pin_reset),
    .irq_take(irq_take), .stack_push(stack_push), .stack_data(stack_data), .pc(pc), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_data(mem_data), .timeout_flag(timeout_flag), .power_down_flag(power_down_flag),
    .imm_reject(imm_reject), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pmv_rom_model u_rom(.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_data(mem_data));
  // remember where the last fetch went
  always @(posedge clk) if (mem_rd === 1'b1) seen_addr <= mem_addr;
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // one apb transfer; waits for pready under a bound
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e, output logic j);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    r = prdata; e = pslverr; j = imm_reject;
    psel <= 0; penable <= 0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err, rej);
  endtask : wr
  task rdr(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0, rd, err, rej);
    chk(name, exp, rd);
  endtask : rdr
  // one-cycle synchronous reset request, watchdog or pin
  task sync_reset(input logic wdt);
    @(posedge clk);
    if (wdt) wdt_reset <= 1; else pin_reset <= 1;
    @(posedge clk);
    wdt_reset <= 0; pin_reset <= 0;
    @(negedge clk);
  endtask : sync_reset
  task t_power;
    chk("pc", 32'h0, 32'(pc));
    chk("timeout_flag", 32'h1, 32'(timeout_flag));
    chk("power_down_flag", 32'h0, 32'(power_down_flag));
    rdr(ADDR_FLAG, 32'h80, "flags");
    rdr(ADDR_ACC, 32'h0, "acc");
    $display("power-on test done");
  endtask : t_power
  task t_sync;
    wr(ADDR_PC, 32'h155); wr(ADDR_ACC, 32'h3c); wr(ADDR_IDXH, 32'h21);
    sync_reset(1'b1);
    chk("pc", 32'h0, 32'(pc));
    rdr(ADDR_FLAG, 32'h00, "flags");
    rdr(ADDR_ACC, 32'h0, "acc");
    rdr(ADDR_IDXH, 32'h0, "idxh");
    wr(ADDR_PC, 32'h0aa);
    sync_reset(1'b0);
    chk("pc", 32'h0, 32'(pc));
    chk("power_down_flag", 32'h1, 32'(power_down_flag));
    rdr(ADDR_FLAG, 32'hc0, "flags");
    $display("sync reset test done");
  endtask : t_sync
  task t_irq;
    wr(ADDR_PC, 32'h123);
    @(posedge clk) irq_take <= 1;
    @(posedge clk) irq_take <= 0;
    @(negedge clk);
    chk("stack_push", 32'h1, 32'(stack_push));
    chk("stack_data", 32'h123, 32'(stack_data));
    chk("pc", 32'(IRQ_VECTOR), 32'(pc));
    wr(ADDR_CTRL, 32'h08);
    @(negedge clk);
    chk("stack_data", 32'(IRQ_VECTOR), 32'(stack_data));
    @(negedge clk);
    chk("stack_push", 32'h0, 32'(stack_push));
    $display("interrupt test done");
  endtask : t_irq
  // cause bits are live 1 while the save holds 0, so pop must keep them
  task t_ctx;
    sync_reset(1'b0);
    wr(ADDR_ACC, 32'h5a); wr(ADDR_FLAG, 32'h15);
    rdr(ADDR_FLAG, 32'hd5, "flags");
    wr(ADDR_CTRL, 32'h02);
    rdr(ADDR_SAVE, 32'h155a, "saved");
    wr(ADDR_ACC, 32'h0); wr(ADDR_FLAG, 32'h0);
    wr(ADDR_CTRL, 32'h04);
    rdr(ADDR_ACC, 32'h5a, "acc");
    rdr(ADDR_FLAG, 32'hd5, "flags");
    $display("context test done");
  endtask : t_ctx
  task t_table;
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_IDXH, 32'(taddr[i][15:8])); wr(ADDR_IDXL, 32'(taddr[i][7:0]));
      wr(ADDR_CTRL, 32'h01);
      n = 0;
      do begin
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err, rej);
        n++;
      end while (rd[0] !== 1'b0 && n < 20);
      // expected word from the image loaded in the memory model
      if (taddr[i] == {6'h00, IRQ_VECTOR}) w = 16'h0000; // no-op at interrupt vector
      else if (taddr[i][9:0] > USER_TOP) w = 16'hffff; // reserved top words
      else w = {taddr[i][7:0] ^ 8'ha5, taddr[i][15:8] ^ 8'h3c};
      chk("mem_addr", 32'(taddr[i]), 32'(seen_addr));
      rdr(ADDR_ACC, 32'(w[7:0]), "acc");
      rdr(ADDR_HIGH, 32'(w[15:8]), "high");
      rdr(ADDR_IDXH, 32'(taddr[i][15:8]), "idxh");
    end
    $display("table read test done");
  endtask : t_table
  task t_refuse;
    apb(1'b1, ADDR_IDXH, 32'he6, rd, err, rej);
    chk("imm_reject", 32'h1, 32'(rej));
    apb(1'b1, ADDR_IDXL, 32'he7, rd, err, rej);
    chk("imm_reject", 32'h1, 32'(rej));
    rdr(ADDR_IDXH, 32'h3f, "idxh");
    rdr(ADDR_IDXL, 32'h00, "idxl");
    apb(1'b0, 8'h40, 32'h0, rd, err, rej);
    chk("pslverr", 32'h1, 32'(err));
    $display("refusal test done");
  endtask : t_refuse
  // clock enable low ignores irq and watchdog; then a mid-run power-on reset
  task t_hold;
    wr(ADDR_PC, 32'h2a5);
    @(posedge clk);
    clk_en <= 0; irq_take <= 1;
    @(posedge clk);
    irq_take <= 0; wdt_reset <= 1;
    @(posedge clk);
    wdt_reset <= 0; clk_en <= 1;
    @(negedge clk);
    chk("pc", 32'h2a5, 32'(pc));
    chk("stack_push", 32'h0, 32'(stack_push));
    chk("power_down_flag", 32'h1, 32'(power_down_flag));
    @(posedge clk);
    reset_n <= 0;
    repeat (2) @(posedge clk);
    reset_n <= 1;
    @(negedge clk);
    chk("pc", 32'h0, 32'(pc));
    chk("timeout_flag", 32'h1, 32'(timeout_flag));
    chk("power_down_flag", 32'h0, 32'(power_down_flag));
    rdr(ADDR_IDXH, 32'h0, "idxh");
    $display("hold and reset test done");
  endtask : t_hold
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1;
    @(negedge clk);
    t_power; t_sync; t_irq; t_ctx; t_table; t_refuse; t_hold;
    complete_run;
  end
  // watchdog: far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    complete_run;
  end
endmodule : pmv_top_bench
`default_nettype wire
